// >>> hw/tcs_top.sv
// timer compare and processor status block with ahb-lite registers
//
// Notes on behaviour
// - match value changes only on software write
// - request timer interrupt when counter equals match
// - request stays until match register written
// - irq enable needs enable=1, exl, erl, debug 0
// - signal only when request priority exceeds current
// - debug flag set means debug mode
// - user mode needs base user, no exl/erl
// - coprocessor usable if bit set or kernel
// - unusable coprocessor access raises an exception
// - reduced power follows bit 27, reset 0
// - byte order reversed only for user references
// - bootstrap vectors when bit 22 set, reset 1
// - soft reset flag set by reset, clear-only
// - nmi flag set by nmi entry, clear-only
// - error level set by reset, nmi, cache error
// - error level forces kernel, no irq, error return
// - error level makes low user segment unmapped
// - unimplemented status bits read as zero
// - counter increments every second cycle unless disabled
// - other exceptions set exception level, except in a cycle that also takes soft reset or nmi
// - global enable masters all interrupts
//
// Register access over AHB-Lite and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
module tcs_top
	import tcs_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        resetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        soft_reset_take,
	input  wire logic        nmi_take,
	input  wire logic        cache_error_take,
	input  wire logic        other_exc_take,
	input  wire logic        exception_return_instr,
	input  wire logic [31:0] exception_return_address,
	input  wire logic [31:0] error_return_address,
	input  wire logic [2:0]  irq_req_priority,
	input  wire logic        irq_req_valid,
	input  wire logic        coproc_access,
	input  wire logic [31:0] data_address,
	output logic             timer_irq_r,
	output logic             irq_signal_r,
	output logic [1:0]       cpu_mode_r,
	output logic             coproc_exc_r,
	output logic             reduced_power_r,
	output logic             byte_order_reverse_r,
	output logic             bootstrap_vector_select_r,
	output logic [31:0]      return_target_r,
	output logic             unmapped_uncached_r
);
	logic [31:0] count_r;
	logic        half_r;
	logic [31:0] match_r;
	logic [31:0] status_r;
	logic [31:0] ctrl_r;
	logic        wr_pend_r;
	logic [7:0]  wr_addr_r;
	logic        acc;
	logic        wr_match;
	logic        wr_status;
	logic        tick;
	logic        kernel;
	logic        user;
	logic        debug_mode_flag;
	logic        irq_en;
	logic        reset_entry_r;
	logic        exc_level_take;

	function automatic logic [31:0] clr_only(input logic [31:0] cur,
		input logic [31:0] wd, input int bit_pos);
		logic [31:0] r;
		r = cur;
		if (!wd[bit_pos]) begin
			r[bit_pos] = 1'b0;
		end
		return r;
	endfunction

	// user mode only with base user and no exception, error or debug
	function automatic logic user_of(input logic [31:0] st,
		input logic dbg);
		return st[TCS_B_UM] && !st[TCS_B_EXL] && !st[TCS_B_ERL] && !dbg;
	endfunction

	// interrupts need the master enable and no exception, error or debug
	function automatic logic irq_en_of(input logic [31:0] st,
		input logic dbg);
		return st[TCS_B_IE] && !st[TCS_B_EXL] && !st[TCS_B_ERL] && !dbg;
	endfunction

	// strict compare: a request at the current level is not signalled
	function automatic logic prio_above(input logic [2:0] req,
		input logic [2:0] cur);
		return req > cur;
	endfunction

	// low user segment: the three top address bits all clear
	function automatic logic low_user_seg(input logic [31:0] addr);
		return addr[31:29] == TCS_SEG_LOW;
	endfunction

	assign acc = hsel && hready && htrans == TCS_HTRANS_NONSEQ;
	assign wr_match  = wr_pend_r && wr_addr_r == TCS_OFF_MATCH;
	assign wr_status = wr_pend_r && wr_addr_r == TCS_OFF_STATUS;
	assign tick = half_r && !ctrl_r[TCS_C_DC];
	assign debug_mode_flag = ctrl_r[TCS_C_DBG];
	// user needs base user and no exception or error level
	assign user = user_of(status_r, debug_mode_flag);
	assign kernel = !user && !debug_mode_flag;
	// error level also masks interrupts
	assign irq_en = irq_en_of(status_r, debug_mode_flag);
	assign exc_level_take = other_exc_take && !soft_reset_take && !nmi_take;

	// write request held over to its data phase, where hwdata stands
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
		end else begin
			wr_pend_r <= acc && hwrite && hsize == {1'b0, TCS_HSIZE_WORD};
			wr_addr_r <= haddr[7:0];
		end
	end

	// slave never inserts wait states
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			hreadyout <= 1'b1;
		end else begin
			hreadyout <= 1'b1;
		end
	end

	// slave always answers okay
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			hresp <= 1'b0;
		end else begin
			hresp <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			hrdata <= 32'h0000_0000;
		end else if (acc && !hwrite) begin
			case (haddr[7:0])
				TCS_OFF_COUNT:  hrdata <= count_r;
				TCS_OFF_MATCH:  hrdata <= match_r;
				TCS_OFF_STATUS: hrdata <= status_r & TCS_STATUS_MASK;
				TCS_OFF_CTRL:   hrdata <= ctrl_r;
				TCS_OFF_MODE:   hrdata <= {30'h0, cpu_mode_r};
				TCS_OFF_ACCESS: hrdata <= {31'h0, timer_irq_r};
				default:        hrdata <= 32'h0000_0000;
			endcase
		end
	end

	// free-running tick counter
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			half_r  <= 1'b0;
			count_r <= TCS_COUNT_RESET;
		end else begin
			half_r <= !half_r;
			if (wr_pend_r && wr_addr_r == TCS_OFF_COUNT) begin
				count_r <= hwdata;
			end else if (tick) begin
				count_r <= count_r + TCS_COUNT_STEP;
			end
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			match_r <= TCS_MATCH_RESET;
		end else if (wr_match) begin
			match_r <= hwdata;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			ctrl_r <= TCS_CTRL_RESET;
		end else if (wr_pend_r && wr_addr_r == TCS_OFF_CTRL) begin
			ctrl_r <= {30'h0, hwdata[1:0]};
		end
	end

	// timer request: match sets, write of match clears; set wins
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			timer_irq_r <= 1'b0;
		end else if (tick && count_r + TCS_COUNT_STEP == match_r) begin
			timer_irq_r <= 1'b1;
		end else if (wr_match) begin
			timer_irq_r <= 1'b0;
		end
	end

	// first cycle after reset release counts as reset entry
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			reset_entry_r <= 1'b1;
		end else begin
			reset_entry_r <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			status_r <= TCS_STATUS_RESET;
		end else begin
			logic [31:0] s;
			s = status_r;
			if (wr_status) begin
				s = (hwdata & TCS_STATUS_MASK);
				s[TCS_B_SR]  = clr_only(status_r, hwdata, TCS_B_SR)[TCS_B_SR];
				s[TCS_B_NMI] = clr_only(status_r, hwdata, TCS_B_NMI)[TCS_B_NMI];
			end
			if (soft_reset_take || reset_entry_r) begin
				s[TCS_B_SR]  = 1'b1;
				s[TCS_B_BEV] = 1'b1;
			end
			if (nmi_take) begin
				s[TCS_B_NMI] = 1'b1;
			end
			if (soft_reset_take || nmi_take || cache_error_take) begin
				s[TCS_B_ERL] = 1'b1;
			end
			if (exc_level_take) begin
				s[TCS_B_EXL] = 1'b1;
			end
			status_r <= s;
		end
	end

	// interrupt signal: enable gating, then strict priority compare
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			irq_signal_r <= 1'b0;
		end else begin
			irq_signal_r <= irq_en && irq_req_valid
				&& prio_above(irq_req_priority,
				status_r[TCS_B_IPL +: 3]);
		end
	end

	// debug overrides the status bits; else user or kernel
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			cpu_mode_r <= TCS_MODE_KERNEL;
		end else begin
			if (debug_mode_flag) begin
				cpu_mode_r <= TCS_MODE_DEBUG;
			end else if (user) begin
				cpu_mode_r <= TCS_MODE_USER;
			end else begin
				cpu_mode_r <= TCS_MODE_KERNEL;
			end
		end
	end

	// kernel and debug always reach the system coprocessor
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			coproc_exc_r <= 1'b0;
		end else begin
			coproc_exc_r <= coproc_access && !kernel && !debug_mode_flag
				&& !status_r[TCS_B_CU0];
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			reduced_power_r <= 1'b0;
		end else begin
			reduced_power_r <= status_r[TCS_B_RP];
		end
	end

	// reversal applies to user references only
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			byte_order_reverse_r <= 1'b0;
		end else begin
			byte_order_reverse_r <= status_r[TCS_B_RE] && user;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			bootstrap_vector_select_r <= 1'b1;
		end else begin
			bootstrap_vector_select_r <= status_r[TCS_B_BEV];
		end
	end

	// return target is latched only when a return executes
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			return_target_r <= 32'h0000_0000;
		end else if (exception_return_instr) begin
			return_target_r <= status_r[TCS_B_ERL] ? error_return_address
				: exception_return_address;
		end
	end

	// low user segment unmapped while error level set
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			unmapped_uncached_r <= 1'b0;
		end else begin
			unmapped_uncached_r <= status_r[TCS_B_ERL]
				&& low_user_seg(data_address);
		end
	end
endmodule // tcs_top

// >>> shared/tcs_pkg.sv
// constants for the timer compare and processor status block
package tcs_pkg;
	localparam logic [7:0] TCS_OFF_COUNT   = 8'h00;
	localparam logic [7:0] TCS_OFF_MATCH   = 8'h04;
	localparam logic [7:0] TCS_OFF_STATUS  = 8'h08;
	localparam logic [7:0] TCS_OFF_CTRL    = 8'h0c;
	localparam logic [7:0] TCS_OFF_MODE    = 8'h10;
	localparam logic [7:0] TCS_OFF_ACCESS  = 8'h14;
	localparam int TCS_B_IE   = 0;
	localparam int TCS_B_EXL  = 1;
	localparam int TCS_B_ERL  = 2;
	localparam int TCS_B_UM   = 4;
	localparam int TCS_B_IPL  = 10;
	localparam int TCS_B_NMI  = 19;
	localparam int TCS_B_SR   = 20;
	localparam int TCS_B_BEV  = 22;
	localparam int TCS_B_RE   = 25;
	localparam int TCS_B_RP   = 27;
	localparam int TCS_B_CU0  = 28;
	localparam logic [31:0] TCS_STATUS_MASK  = 32'h1a58_1c17;
	localparam logic [31:0] TCS_MATCH_RESET  = 32'hffff_ffff;
	localparam logic [31:0] TCS_COUNT_RESET  = 32'h0000_0000;
	localparam logic [31:0] TCS_COUNT_STEP   = 32'h0000_0001;
	localparam logic [2:0]  TCS_SEG_LOW      = 3'b000;
	localparam logic [31:0] TCS_STATUS_RESET = 32'h0050_0004;
	localparam logic [31:0] TCS_CTRL_RESET   = 32'h0000_0000;
	localparam int TCS_C_DC   = 0;
	localparam int TCS_C_DBG  = 1;
	localparam logic [1:0] TCS_HTRANS_NONSEQ = 2'b10;
	localparam logic [1:0] TCS_HSIZE_WORD    = 2'b10;
	typedef enum logic [1:0] {
		TCS_MODE_KERNEL = 2'b00,
		TCS_MODE_USER   = 2'b01,
		TCS_MODE_DEBUG  = 2'b10
	} tcs_mode_type;
endpackage

// >>> tb/tb_tcs_top.sv
// self-checking bench for the timer compare and status block
`timescale 1ns/1ns
module tb_tcs_top
	import tcs_pkg::*;
;
	logic clock = 0, hsel = 0, hwrite = 0, sw = 0;
	logic resetn;
	logic exception_return_instr = 0, coproc_access = 0;
	logic [31:0] haddr = 0, hwdata = 0, data_address = 0, q, e, d, s, p;
	logic [31:0] exception_return_address = 0, error_return_address = 0;
	logic [1:0] htrans = 0, m;
	logic [2:0] hsize = TCS_HSIZE_WORD, pri = 0;
	logic [3:0] ev = 0;
	logic [31:0] hrdata, return_target_r;
	logic hreadyout, hresp, timer_irq_r, irq_signal_r, coproc_exc_r;
	logic reduced_power_r, byte_order_reverse_r, unmapped_uncached_r;
	logic bootstrap_vector_select_r, irq_req_valid;
	logic [1:0] cpu_mode_r;
	logic [2:0] irq_req_priority;
	wire hready = hreadyout;
	wire soft_reset_take = ev[0], nmi_take = ev[1];
	wire cache_error_take = ev[2], other_exc_take = ev[3];
	int seed = 32'hfd8916c1, error_cnt = 0, total_checks = 0, i;
	logic [31:0] evx [4] = '{32'h0010_0004, 32'h0008_0004, 32'h4, 32'h2};
	tcs_top tcs_top_inst (.*);
	tcs_intc_model tcs_intc_model_inst (.*);
	always #5 clock = ~clock;
	task results;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task chk(string n, logic [31:0] x, logic [31:0] g);
		total_checks++;
		if (g !== x) begin
			error_cnt++;
			$display("BAD %s exp %h got %h", n, x, g);
		end
	endtask
	task wt;
		for (int n = 0; n < 99; n++) begin
			@(posedge clock);
			if (hready === 1'b1) return;
		end
		error_cnt++;
		results;
	endtask
	task bus(logic w, logic [7:0] a, logic [31:0] wd);
		hsel <= 1;
		htrans <= TCS_HTRANS_NONSEQ;
		hwrite <= w;
		haddr <= {24'h0, a};
		wt;
		hsel <= 0;
		htrans <= 2'b00;
		hwdata <= wd;
		wt;
		q = hrdata;
	endtask
	function logic [1:0] mode_of(logic [31:0] st, logic dbg);
		if (dbg) return TCS_MODE_DEBUG;
		if (st[TCS_B_UM] && !st[TCS_B_EXL] && !st[TCS_B_ERL])
			return TCS_MODE_USER;
		return TCS_MODE_KERNEL;
	endfunction
	initial begin
		resetn <= 1'b0;
		repeat (20) @(posedge clock);
		resetn <= 1;
		@(posedge clock);
		bus(0, TCS_OFF_STATUS, 0);
		chk("rst", TCS_STATUS_RESET, q);
		bus(1, TCS_OFF_STATUS, 32'hffff_ffff);
		bus(0, TCS_OFF_STATUS, 0);
		chk("ones", TCS_STATUS_MASK & 32'hfff7_ffff, q);
		for (i = 0; i < 40; i++) begin
			s = $random(seed);
			d = $random(seed);
			p = q;
			bus(1, TCS_OFF_CTRL, {30'h0, d[0], 1'b0});
			bus(1, TCS_OFF_STATUS, s);
			pri <= d[3:1];
			sw <= d[4];
			coproc_access <= d[5];
			data_address <= $random(seed);
			repeat (3) @(posedge clock);
			e = (s & TCS_STATUS_MASK & 32'hffe7_ffff)
				| (p & s & 32'h0018_0000);
			m = mode_of(e, d[0]);
			chk("mode", m, cpu_mode_r);
			chk("rp", e[27], reduced_power_r);
			chk("rev", e[25] && m == TCS_MODE_USER, byte_order_reverse_r);
			chk("bev", e[22], bootstrap_vector_select_r);
			chk("cop", d[5] && m == 1 && !e[28], coproc_exc_r);
			chk("irq", sw && e[0] && !e[1] && !e[2] && !d[0]
				&& d[3:1] > e[12:10], irq_signal_r);
			chk("seg", e[2] && data_address[31:29] == 0,
				unmapped_uncached_r);
			bus(0, TCS_OFF_STATUS, 0);
			chk("stat", e, q);
		end
		$display("test status done");
		for (i = 0; i < 4; i++) begin
			bus(1, TCS_OFF_STATUS, 0);
			ev <= 4'h1 << i;
			@(posedge clock);
			ev <= 0;
			bus(0, TCS_OFF_STATUS, 0);
			chk("event", evx[i], q & 32'hffbf_ffff);
		end
		exception_return_address <= $random(seed);
		error_return_address <= $random(seed);
		for (i = 0; i < 2; i++) begin
			bus(1, TCS_OFF_STATUS, {29'h0, i[0], 2'b00});
			exception_return_instr <= 1;
			@(posedge clock);
			exception_return_instr <= 0;
			repeat (2) @(posedge clock);
			chk("ret", i ? error_return_address : exception_return_address,
				return_target_r);
		end
		$display("test events done");
		bus(1, TCS_OFF_CTRL, 0);
		bus(1, TCS_OFF_COUNT, 0);
		repeat (40) @(posedge clock);
		bus(0, TCS_OFF_COUNT, 0);
		chk("rate", 32'd20, q);
		bus(1, TCS_OFF_COUNT, 0);
		bus(1, TCS_OFF_MATCH, 32'h20);
		for (i = 0; i < 200 && timer_irq_r !== 1; i++) @(posedge clock);
		chk("tirq", 1, timer_irq_r);
		repeat (20) @(posedge clock);
		chk("hold", 1, timer_irq_r);
		bus(0, TCS_OFF_MATCH, 0);
		chk("match", 32'h20, q);
		bus(1, TCS_OFF_MATCH, 32'h1000);
		@(posedge clock);
		chk("tclr", 0, timer_irq_r);
		bus(1, TCS_OFF_CTRL, 1);
		bus(0, TCS_OFF_COUNT, 0);
		e = q;
		repeat (10) @(posedge clock);
		bus(0, TCS_OFF_COUNT, 0);
		chk("dc", e, q);
		bus(1, 8'h20, 32'hffff_ffff);
		bus(0, 8'h20, 0);
		chk("hole", 0, q);
		$display("test timer done");
		results;
	end
endmodule // tb_tcs_top

// >>> tb/tcs_chk.sv
// port assertions for the timer compare and status block
`timescale 1ns/1ns
module tcs_chk
	import tcs_pkg::*;
(
	input wire logic        clock,
	input wire logic        resetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic        timer_irq_r,
	input wire logic        irq_signal_r,
	input wire logic        irq_req_valid,
	input wire logic [1:0]  cpu_mode_r,
	input wire logic        coproc_exc_r,
	input wire logic        coproc_access,
	input wire logic        byte_order_reverse_r,
	input wire logic        unmapped_uncached_r,
	input wire logic [31:0] data_address
);
	wire mw = hsel && hwrite && htrans == TCS_HTRANS_NONSEQ
		&& haddr[7:0] == TCS_OFF_MATCH;
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	a_ready_high: assert property (hreadyout) else $error("hready low");
	a_resp_okay: assert property (!hresp) else $error("hresp not okay");
	a_mode_legal: assert property (cpu_mode_r != 2'b11)
		else $error("bad mode code");
	a_irq_hold: assert property ($fell(timer_irq_r) |-> $past(mw)
		|| $past(mw, 2)) else $error("timer request dropped");
	a_rev_user: assert property (byte_order_reverse_r
		|-> cpu_mode_r == TCS_MODE_USER) else $error("reverse off user");
	a_cop_cause: assert property (coproc_exc_r
		|-> $past(coproc_access)) else $error("stray coproc fault");
	a_irq_cause: assert property (irq_signal_r
		|-> $past(irq_req_valid)) else $error("irq without request");
	a_low_seg: assert property (unmapped_uncached_r
		|-> $past(data_address[31:29]) == 3'h0) else $error("bad unmapped");
endmodule // tcs_chk
bind tcs_top tcs_chk tcs_chk_inst (.*);

// >>> tb/tcs_intc_model.sv
// interrupt controller model taking the timer request
`timescale 1ns/1ns
module tcs_intc_model (
	input  wire logic       clock,
	input  wire logic       resetn,
	input  wire logic       timer_irq_r,
	input  wire logic       sw,
	input  wire logic [2:0] pri,
	output logic            irq_req_valid,
	output logic [2:0]      irq_req_priority
);
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			irq_req_valid <= 1'b0;
			irq_req_priority <= 3'h0;
		end else begin
			irq_req_valid <= timer_irq_r | sw;
			irq_req_priority <= timer_irq_r ? 3'h7 : pri;
		end
	end
endmodule // tcs_intc_model
